// file: design/queue_pkg.sv
// shared constants, types and helpers for the queue
package queue_pkg;

	// storage technology behind the queue
	typedef enum logic [3:0] {
		MEM_BLOCK = 4'h1,
		MEM_DIST = 4'h2,
		MEM_SHIFT = 4'h4,
		MEM_BUILTIN = 4'h8
	} mem_kind_t;

	// legal build ranges of the write port
	localparam int MIN_WIDTH = 1;
	localparam int MAX_WIDTH = 1024;
	localparam int MIN_DEPTH = 16;
	localparam int MAX_DEPTH = 4194304;

	// build defaults
	localparam int DEF_WIDTH = 18;
	localparam int DEF_DEPTH = 1024;
	localparam int DEF_MACRO_DEPTH = 512;
	localparam logic FULL_RST_DEF = 1'h1;

	// number of hamming check bits protecting w data bits
	function automatic int ecc_par_bits(input int w);
		int p;
		p = 0;
		while ((1 << p) < (w + p + 1)) begin
			p++;
		end
		return p;
	endfunction

	// full code width: data, check bits and one overall parity bit
	function automatic int ecc_code_width(input int w);
		return w + ecc_par_bits(w) + 1;
	endfunction

endpackage

// file: design/ecc_link_if.sv
// signals between the queue core and its error-correcting codec
`timescale 1ns/1ps
interface ecc_link_if #(
	parameter int DW = 8,
	parameter int CW = 13
);
	logic [DW-1:0] enc_data;
	logic inj_single;
	logic inj_double;
	logic [CW-1:0] enc_code;
	logic [CW-1:0] dec_code;
	logic [DW-1:0] dec_data;
	logic dec_single;
	logic dec_double;

	modport core (
		output enc_data, inj_single, inj_double, dec_code,
		input enc_code, dec_data, dec_single, dec_double
	);
	modport codec (
		input enc_data, inj_single, inj_double, dec_code,
		output enc_code, dec_data, dec_single, dec_double
	);
endinterface

// file: design/ecc_codec.sv
// single-error-correct double-error-detect codec, purely combinational
`timescale 1ns/1ps
module ecc_codec
	import queue_pkg::*;
#(
	parameter int DW = 8,
	parameter int CW = 13
) (
	ecc_link_if.codec cx
);
	localparam int P = ecc_par_bits(DW);
	localparam int N = DW + P;

	// hamming positions 1..N, bit 0 holds parity over the whole word
	function automatic logic [CW-1:0] encode(input logic [DW-1:0] d);
		logic [CW-1:0] c;
		int k;
		c = '0;
		k = 0;
		for (int i = 1; i <= N; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = d[k];
				k++;
			end
		end
		for (int b = 0; b < P; b++) begin
			for (int i = 1; i <= N; i++) begin
				if (i[b] && ((i & (i - 1)) != 0)) begin
					c[1 << b] = c[1 << b] ^ c[i];
				end
			end
		end
		c[0] = ^c[CW-1:1];
		return c;
	endfunction

	// encoder with error injection; parity bits are flipped so any width works
	always_comb begin
		cx.enc_code = encode(cx.enc_data);
		if (cx.inj_double) begin
			cx.enc_code[1] = ~cx.enc_code[1];
			cx.enc_code[2] = ~cx.enc_code[2];
		end else if (cx.inj_single) begin
			cx.enc_code[1] = ~cx.enc_code[1];
		end
	end

	// decoder: syndrome locates a single flip, overall parity tells one from two
	always_comb begin
		logic [CW-1:0] c;
		logic [P-1:0] syn;
		logic odd;
		int k;
		c = cx.dec_code;
		odd = ^cx.dec_code;
		syn = '0;
		k = 0;
		for (int b = 0; b < P; b++) begin
			for (int i = 1; i <= N; i++) begin
				if (i[b]) begin
					syn[b] = syn[b] ^ c[i];
				end
			end
		end
		if (odd && (syn != '0) && (int'(syn) <= N)) begin
			c[syn] = ~c[syn];
		end
		cx.dec_data = '0;
		for (int i = 1; i <= N; i++) begin
			if ((i & (i - 1)) != 0) begin
				cx.dec_data[k] = c[i];
				k++;
			end
		end
		cx.dec_single = odd;
		cx.dec_double = !odd && (syn != '0);
	end
endmodule

// file: design/native_queue.sv
// configurable first-in first-out queue with native write and read ports
`timescale 1ns/1ps
module native_queue
	import queue_pkg::*;
#(
	parameter int WR_WIDTH = DEF_WIDTH,
	parameter int WR_DEPTH = DEF_DEPTH,
	parameter int RD_WIDTH = DEF_WIDTH,
	parameter mem_kind_t MEM_KIND = MEM_BLOCK,
	parameter bit INDEP_CLK = 1'b0,
	parameter bit LOOKAHEAD_READ_MODE = 1'b0,
	parameter bit ECC_EN = 1'b0,
	parameter bit INJ_SINGLE_EN = 1'b0,
	parameter bit INJ_DOUBLE_EN = 1'b0,
	parameter bit OUT_REG = 1'b0,
	parameter int MACRO_DEPTH = DEF_MACRO_DEPTH,
	parameter bit HAS_RESET = 1'b1,
	parameter bit RESET_SYNC = 1'b1,
	parameter bit ASYNC_RESET = 1'b0,
	parameter logic FULL_RST_VAL = FULL_RST_DEF,
	parameter bit DOUT_RST_EN = 1'b0,
	parameter logic [RD_WIDTH-1:0] DOUT_RST_VAL = '0,
	parameter int THRESH_FULL = WR_DEPTH - 1
) (
	input wire logic ref_clk,
	input wire logic ce,
	input wire logic rst_n,
	input wire logic wr_rst_n,
	input wire logic rd_rst_n,
	input wire logic wr_en,
	input wire logic [WR_WIDTH-1:0] din,
	input wire logic inj_sbit_err,
	input wire logic inj_dbit_err,
	input wire logic rd_en,
	output logic [RD_WIDTH-1:0] dout,
	output logic dout_valid,
	output logic full,
	output logic almost_full,
	output logic threshold_full_flag,
	output logic empty,
	output logic sbit_err,
	output logic dbit_err
);
	// storage kinds that allow the optional features
	localparam bit RAM_KIND = (MEM_KIND == MEM_BLOCK) || (MEM_KIND == MEM_DIST);
	localparam bit ECC_KIND = (MEM_KIND == MEM_BLOCK) || (MEM_KIND == MEM_BUILTIN);

	// depth outside the legal set falls back to the smallest legal depth
	localparam bit DEPTH_OK = (WR_DEPTH >= MIN_DEPTH) && (WR_DEPTH <= MAX_DEPTH)
		&& ((WR_DEPTH & (WR_DEPTH - 1)) == 0);
	localparam int DEPTH = DEPTH_OK ? WR_DEPTH : MIN_DEPTH;
	localparam bit WIDTH_OK = (WR_WIDTH >= MIN_WIDTH) && (WR_WIDTH <= MAX_WIDTH);

	// port width ratio, kept to a power of two so the pointers wrap cleanly
	localparam int WMIN = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH;
	localparam int WMAX = (WR_WIDTH < RD_WIDTH) ? RD_WIDTH : WR_WIDTH;
	localparam int RATIO = WMAX / WMIN;
	localparam bit ASYM = WIDTH_OK && (WR_WIDTH != RD_WIDTH) && INDEP_CLK
		&& (MEM_KIND == MEM_BLOCK) && ((WMAX % WMIN) == 0)
		&& ((RATIO & (RATIO - 1)) == 0) && !ECC_EN;
	localparam int UW = ASYM ? WMIN : WR_WIDTH;
	localparam int WRU = WR_WIDTH / UW;
	localparam int RDU = ASYM ? (RD_WIDTH / UW) : 1;
	localparam int RDW = RDU * UW;
	localparam int TOTAL = DEPTH * WRU;
	localparam int RD_DEPTH = TOTAL / RDU;
	localparam int AW = $clog2(TOTAL);

	// features resolved against the storage kind
	localparam bit LA_EFF = LOOKAHEAD_READ_MODE && RAM_KIND;
	localparam bit ECC_EFF = ECC_EN && ECC_KIND && !ASYM;
	localparam bit INJ_S_EFF = ECC_EFF && INJ_SINGLE_EN;
	localparam bit INJ_D_EFF = ECC_EFF && INJ_DOUBLE_EN;
	localparam bit OUT_REG_EFF = OUT_REG && !LA_EFF
		&& ((MEM_KIND != MEM_BUILTIN) || (!INDEP_CLK && (DEPTH <= MACRO_DEPTH)));
	localparam bit HAS_RST_EFF = HAS_RESET || !RAM_KIND;
	localparam bit ASYNC_EFF = HAS_RST_EFF && ASYNC_RESET && !INDEP_CLK && RAM_KIND;
	localparam bit DOUT_RST_EFF = DOUT_RST_EN && HAS_RST_EFF;

	localparam int CW = ECC_EFF ? ecc_code_width(WR_WIDTH) : 1;
	localparam int SW = ECC_EFF ? CW : UW;

	// fill thresholds in storage units
	localparam logic [AW:0] FULL_AT = (AW + 1)'(TOTAL - WRU + 1);
	localparam logic [AW:0] AFULL_AT = (AW + 1)'(TOTAL - WRU);
	localparam logic [AW:0] THRESH_AT = (AW + 1)'(THRESH_FULL * WRU);
	localparam logic [AW:0] RD_NEED = (AW + 1)'(RDU);
	localparam logic [AW:0] WR_STEP = (AW + 1)'(WRU);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [RD_WIDTH-1:0] pipe;
		logic pipe_v;
		logic pipe_s;
		logic pipe_d;
		logic [RD_WIDTH-1:0] dout;
		logic dout_v;
		logic err_s;
		logic err_d;
		logic [2:0] rsync;
		logic rst_seen;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic [SW-1:0] mem [TOTAL];
	logic [WRU-1:0][SW-1:0] wr_units;
	logic [RDU-1:0][SW-1:0] rd_units;
	logic [RDW-1:0] rd_word;
	logic [RD_WIDTH-1:0] mem_word;
	logic mem_s;
	logic mem_d;
	logic rst_act;
	logic full_i;
	logic have_rd;
	logic wr_ok;
	logic mem_rd;

	ecc_link_if #(.DW(WR_WIDTH), .CW(CW)) cx ();

	// which reset is in force; separate resets are honoured only with independent clocks and RESET_SYNC off
	always_comb begin
		if (!HAS_RST_EFF) begin
			rst_act = 1'b0;
		end else if (INDEP_CLK && RESET_SYNC) begin
			rst_act = st_r.rst_seen;
		end else if (INDEP_CLK) begin
			rst_act = !wr_rst_n || !rd_rst_n;
		end else begin
			rst_act = !rst_n;
		end
	end

	// split the write word into units, first unit from the top bits
	generate
		for (genvar j = 0; j < WRU; j++) begin : g_wr
			if (ECC_EFF) begin : g_code
				assign wr_units[j] = cx.enc_code;
			end else begin : g_raw
				assign wr_units[j] = SW'(din[WR_WIDTH-1-j*UW -: UW]);
			end
		end
		for (genvar k = 0; k < RDU; k++) begin : g_rd
			assign rd_units[k] = mem[st_r.rp + AW'(k)];
			assign rd_word[RDW-1-k*UW -: UW] = rd_units[k][UW-1:0];
		end
	endgenerate

	// codec only exists when correction is built in
	generate
		if (ECC_EFF) begin : g_ecc
			ecc_codec #(.DW(WR_WIDTH), .CW(CW)) u_codec (
				.cx(cx)
			);
			assign mem_word = RD_WIDTH'(cx.dec_data);
			assign mem_s = cx.dec_single;
			assign mem_d = cx.dec_double;
		end else begin : g_noecc
			assign cx.enc_code = '0;
			assign cx.dec_data = '0;
			assign cx.dec_single = 1'b0;
			assign cx.dec_double = 1'b0;
			assign mem_word = RD_WIDTH'(rd_word);
			assign mem_s = 1'b0;
			assign mem_d = 1'b0;
		end
	endgenerate

	// codec inputs, injection held off unless built in
	assign cx.enc_data = din;
	assign cx.inj_single = INJ_S_EFF && inj_sbit_err;
	assign cx.inj_double = INJ_D_EFF && inj_dbit_err;
	assign cx.dec_code = CW'(rd_units[0]);

	// occupancy decisions come straight from the registered count
	assign full_i = st_r.cnt >= FULL_AT;
	assign have_rd = st_r.cnt >= RD_NEED;
	assign wr_ok = wr_en && !full_i && !rst_act;

	// next state: pointers, count, read path and reset synchroniser
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsync = {st_r.rsync[1:0], rst_n};
		if (st_r.rsync[1] == st_r.rsync[2]) begin
			st_nxt.rst_seen = !st_r.rsync[2];
		end
		// lookahead refills its head whenever the head is free or being taken
		if (LA_EFF) begin
			mem_rd = (!st_r.dout_v || rd_en) && have_rd && !rst_act;
		end else begin
			mem_rd = rd_en && have_rd && !rst_act;
		end
		if (wr_ok) begin
			st_nxt.wp = st_r.wp + AW'(WRU);
		end
		if (mem_rd) begin
			st_nxt.rp = st_r.rp + AW'(RDU);
		end
		st_nxt.cnt = st_r.cnt + (wr_ok ? WR_STEP : '0) - (mem_rd ? RD_NEED : '0);
		if (LA_EFF) begin
			// head register is the output itself
			if (mem_rd) begin
				st_nxt.dout = mem_word;
				st_nxt.dout_v = 1'b1;
				st_nxt.err_s = mem_s;
				st_nxt.err_d = mem_d;
			end else if (rd_en && st_r.dout_v) begin
				st_nxt.dout_v = 1'b0;
			end
		end else if (OUT_REG_EFF) begin
			// one extra stage between memory and output
			st_nxt.pipe_v = mem_rd;
			if (mem_rd) begin
				st_nxt.pipe = mem_word;
				st_nxt.pipe_s = mem_s;
				st_nxt.pipe_d = mem_d;
			end
			st_nxt.dout_v = st_r.pipe_v;
			if (st_r.pipe_v) begin
				st_nxt.dout = st_r.pipe;
				st_nxt.err_s = st_r.pipe_s;
				st_nxt.err_d = st_r.pipe_d;
			end
		end else begin
			// memory read latch only, no further register
			st_nxt.dout_v = mem_rd;
			if (mem_rd) begin
				st_nxt.dout = mem_word;
				st_nxt.err_s = mem_s;
				st_nxt.err_d = mem_d;
			end
		end
		// synchronous reset leaves the synchroniser running
		if (rst_act) begin
			st_nxt.wp = '0;
			st_nxt.rp = '0;
			st_nxt.cnt = '0;
			st_nxt.pipe_v = 1'b0;
			st_nxt.dout_v = 1'b0;
			st_nxt.pipe_s = 1'b0;
			st_nxt.pipe_d = 1'b0;
			st_nxt.err_s = 1'b0;
			st_nxt.err_d = 1'b0;
			if (DOUT_RST_EFF) begin
				st_nxt.dout = DOUT_RST_VAL;
				st_nxt.pipe = DOUT_RST_VAL;
			end
		end
	end

	// state register; clock enable low freezes everything but the asynchronous reset
	generate
		if (ASYNC_EFF) begin : g_areg
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					st_r.wp <= '0;
					st_r.rp <= '0;
					st_r.cnt <= '0;
					st_r.pipe_v <= 1'b0;
					st_r.dout_v <= 1'b0;
					st_r.pipe_s <= 1'b0;
					st_r.pipe_d <= 1'b0;
					st_r.err_s <= 1'b0;
					st_r.err_d <= 1'b0;
					// data left alone unless an output reset value is built in
					if (DOUT_RST_EFF) begin
						st_r.dout <= DOUT_RST_VAL;
						st_r.pipe <= DOUT_RST_VAL;
					end
				end else if (ce) begin
					st_r <= st_nxt;
				end
			end
		end else begin : g_sreg
			always_ff @(posedge ref_clk) begin
				if (ce) begin
					st_r <= st_nxt;
				end
			end
		end
	endgenerate

	// storage array, never reset so it maps onto plain memory
	always_ff @(posedge ref_clk) begin
		if (ce && wr_ok) begin
			for (int j = 0; j < WRU; j++) begin
				mem[st_r.wp + AW'(j)] <= wr_units[j];
			end
		end
	end

	// outputs; without output reset the data port keeps its last word
	assign dout = st_r.dout;
	assign dout_valid = st_r.dout_v;
	assign sbit_err = st_r.err_s;
	assign dbit_err = st_r.err_d;
	assign empty = LA_EFF ? !st_r.dout_v : !have_rd;

	// full family reports the chosen value while reset is held
	always_comb begin
		if (rst_act) begin
			full = FULL_RST_VAL;
			almost_full = FULL_RST_VAL;
			threshold_full_flag = FULL_RST_VAL;
		end else begin
			full = full_i;
			almost_full = st_r.cnt >= AFULL_AT;
			threshold_full_flag = st_r.cnt >= THRESH_AT;
		end
	end

endmodule

// file: tb/queue_asserts.sv
// concurrent port checks for the native queue
`timescale 1ns/1ps
module queue_asserts #(
	parameter int RD_WIDTH = 8,
	parameter logic FULL_RST_VAL = 1'h1,
	parameter logic [RD_WIDTH-1:0] DOUT_RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic ce,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [RD_WIDTH-1:0] dout,
	input wire logic dout_valid,
	input wire logic full,
	input wire logic almost_full,
	input wire logic threshold_full_flag,
	input wire logic empty,
	input wire logic sbit_err,
	input wire logic dbit_err
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// a read the queue must take, and a lone write
	sequence s_rd;
		ce && rd_en && !empty;
	endsequence
	sequence s_wr;
		ce && wr_en && !rd_en;
	endsequence
	property p_rd_lat;
		s_rd |=> dout_valid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
	property p_vld_cause;
		dout_valid |-> $past(ce && rd_en && !empty);
	endproperty
	a_vld_cause: assert property (p_vld_cause) else $error("stray valid");
	property p_no_rd;
		ce && rd_en && empty |=> !dout_valid;
	endproperty
	a_no_rd: assert property (p_no_rd) else $error("read while empty taken");
	property p_full_hold;
		ce && full && !rd_en |=> full;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full dropped");
	property p_af_fill;
		s_wr and almost_full && !full |=> full;
	endproperty
	a_af_fill: assert property (p_af_fill) else $error("last slot not filled");
	property p_af_room;
		s_wr and !almost_full |=> !full;
	endproperty
	a_af_room: assert property (p_af_room) else $error("full too early");
	property p_full_af;
		full |-> almost_full && threshold_full_flag;
	endproperty
	a_full_af: assert property (p_full_af) else $error("flags disagree");
	property p_wr_fill;
		ce && empty && wr_en |=> !empty;
	endproperty
	a_wr_fill: assert property (p_wr_fill) else $error("write lost");
	property p_err_excl;
		sbit_err |-> !dbit_err;
	endproperty
	a_err_excl: assert property (p_err_excl) else $error("both error flags");
	property p_hold;
		!(ce && rd_en && !empty) |=> $stable(dout) && $stable(sbit_err) && $stable(dbit_err);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst;
		$rose(rst_n) |-> dout == DOUT_RST_VAL && empty && $past(full) == FULL_RST_VAL
			&& $past(almost_full) == FULL_RST_VAL && $past(threshold_full_flag) == FULL_RST_VAL;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset values");
endmodule
bind native_queue queue_asserts #(.RD_WIDTH(RD_WIDTH), .FULL_RST_VAL(FULL_RST_VAL),
	.DOUT_RST_VAL(DOUT_RST_VAL)) i_chk (.ref_clk(ref_clk), .ce(ce), .rst_n(rst_n),
	.wr_en(wr_en), .rd_en(rd_en), .dout(dout), .dout_valid(dout_valid), .full(full),
	.almost_full(almost_full), .threshold_full_flag(threshold_full_flag), .empty(empty),
	.sbit_err(sbit_err), .dbit_err(dbit_err));

// file: tb/queue_reader.sv
// partner model: consumer logic that drains the queue and logs words
`timescale 1ns/1ps
module queue_reader #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic drain,
	input wire logic slow,
	input wire logic dout_valid,
	input wire logic [W-1:0] dout,
	input wire logic sbit_err,
	input wire logic dbit_err,
	output logic rd_en
);
	logic [W+1:0] got[$];
	logic ph = 1'h0;
	initial rd_en = 1'h0;
	// slow mode stalls every other cycle; never reads before reset ends
	always @(posedge ref_clk) begin
		ph <= !ph;
		rd_en <= rst_n && drain && (!slow || ph);
		if (dout_valid === 1'h1) begin
			got.push_back({dbit_err, sbit_err, dout});
		end
	end
endmodule

// file: tb/tb_native_queue.sv
// self-checking bench for the queue in its common-clock ecc build
`timescale 1ns/1ps
module tb_native_queue;
	import queue_pkg::*;
	localparam logic [7:0] RST_VAL = 8'h5A;
	localparam int DW = 8;
	localparam int DEPTH = 16;
	localparam bit ON = 1'h1;
	logic ref_clk = 1'h0;
	logic ce = 1'h1;
	logic rst_n = 1'h0;
	logic wr_en = 1'h0;
	logic [7:0] din = 8'h00;
	logic inj_s = 1'h0;
	logic inj_d = 1'h0;
	logic drain = 1'h0;
	logic slow = 1'h0;
	logic rd_en;
	logic [7:0] dout;
	logic dout_valid, full, almost_full, thr, empty, sbit_err, dbit_err;
	int fails = 0;
	int check_count = 0;
	// side resets follow the main reset so both domains are reset together
	native_queue #(.WR_WIDTH(DW), .WR_DEPTH(DEPTH), .RD_WIDTH(DW), .ECC_EN(ON),
		.INJ_SINGLE_EN(ON), .INJ_DOUBLE_EN(ON), .DOUT_RST_EN(ON),
		.DOUT_RST_VAL(RST_VAL)) i_dut (.ref_clk(ref_clk), .ce(ce), .rst_n(rst_n),
		.wr_rst_n(rst_n), .rd_rst_n(rst_n), .wr_en(wr_en), .din(din), .inj_sbit_err(inj_s),
		.inj_dbit_err(inj_d), .rd_en(rd_en), .dout(dout), .dout_valid(dout_valid),
		.full(full), .almost_full(almost_full), .threshold_full_flag(thr),
		.empty(empty), .sbit_err(sbit_err), .dbit_err(dbit_err));
	queue_reader #(.W(DW)) i_rd (.ref_clk(ref_clk), .rst_n(rst_n), .drain(drain),
		.slow(slow), .dout_valid(dout_valid), .dout(dout), .sbit_err(sbit_err),
		.dbit_err(dbit_err), .rd_en(rd_en));
	always #2 ref_clk = !ref_clk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one write cycle; back-to-back calls keep the strobe up
	task automatic wr(input logic [7:0] d, input logic s, input logic dd);
		@(posedge ref_clk);
		wr_en <= 1'h1;
		din <= d;
		inj_s <= s;
		inj_d <= dd;
	endtask
	task automatic idle();
		@(posedge ref_clk);
		wr_en <= 1'h0;
		inj_s <= 1'h0;
		inj_d <= 1'h0;
	endtask
	// drain n words; the tail cycles catch any extra word wrongly read
	task automatic take(input int n);
		int k;
		k = 0;
		i_rd.got.delete();
		drain <= 1'h1;
		while (i_rd.got.size() < n && k < 200) begin
			@(posedge ref_clk);
			k++;
		end
		drain <= 1'h0;
		repeat (6) @(posedge ref_clk);
		if (k == 200) begin
			fails++;
			finish_test();
		end
		chk(i_rd.got.size(), n);
	endtask
	task automatic t_reset();
		chk({full, almost_full, thr}, 3'h7);
		chk(dout, RST_VAL);
		chk(empty, 1'h1);
		$display("test reset done");
	endtask
	task automatic t_fill();
		for (int i = 0; i < 16; i++) begin
			wr(8'hA0 + i[7:0], 1'h0, 1'h0);
			if (i == 15) begin
				#1 chk({almost_full, full}, 2'h2);
			end
		end
		wr(8'hEE, 1'h0, 1'h0);
		#1 chk({full, almost_full, thr}, 3'h7);
		idle();
		slow <= 1'h1;
		take(16);
		for (int i = 0; i < 16; i++) begin
			chk(i_rd.got[i], {2'h0, 8'hA0 + i[7:0]});
		end
		chk(empty, 1'h1);
		slow <= 1'h0;
		$display("test fill done");
	endtask
	task automatic t_ecc();
		wr(8'h3C, 1'h1, 1'h0);
		wr(8'hC3, 1'h0, 1'h1);
		wr(8'h81, 1'h1, 1'h1);
		wr(8'h7E, 1'h0, 1'h0);
		idle();
		take(4);
		chk(i_rd.got[0], {2'h1, 8'h3C});
		chk(i_rd.got[1], {2'h2, 8'hC3});
		chk(i_rd.got[2], {2'h2, 8'h81});
		chk(i_rd.got[3], {2'h0, 8'h7E});
		$display("test ecc done");
	endtask
	// clock enable low freezes the queue; a write offered then never lands
	task automatic t_ce();
		@(posedge ref_clk);
		ce <= 1'h0;
		wr_en <= 1'h1;
		din <= 8'h55;
		repeat (3) @(posedge ref_clk);
		#1 chk({empty, full, almost_full}, 3'h4);
		@(posedge ref_clk);
		ce <= 1'h1;
		wr_en <= 1'h0;
		repeat (2) @(posedge ref_clk);
		#1 chk({empty, full, almost_full}, 3'h4);
		chk(dout, 8'h7E);
		$display("test ce done");
	endtask
	// reset with a word still queued and a write refused meanwhile
	task automatic t_midrst();
		wr(8'h11, 1'h0, 1'h0);
		wr(8'h22, 1'h0, 1'h0);
		idle();
		take(2);
		chk(dout, 8'h22);
		wr(8'h33, 1'h0, 1'h0);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		din <= 8'h99;
		repeat (2) @(posedge ref_clk);
		#1 t_reset();
		@(posedge ref_clk);
		rst_n <= 1'h1;
		wr_en <= 1'h0;
		#1 chk(empty, 1'h1);
		wr(8'h44, 1'h0, 1'h0);
		idle();
		take(1);
		chk(i_rd.got[0], {2'h0, 8'h44});
		$display("test midrst done");
	endtask
	initial begin
		repeat (15) @(posedge ref_clk);
		#1 t_reset();
		@(posedge ref_clk);
		rst_n <= 1'h1;
		t_fill();
		t_ecc();
		t_ce();
		t_midrst();
		finish_test();
	end
endmodule
